//--- tb_top.sv
// Self-checking bench for the time-base line buffer
`timescale 1ns/1ps
module tb_top;
  logic clk, reset, tape_clk, ref_take, tape_ready, tape_valid, tape_dropout;
  logic [7:0] tape_sample, out_sample;
  logic out_valid, out_substituted, out_empty;
  logic [14:0] out_fill;
  logic [31:0] want;
  int sent, stalls, miscompares, n_tests, rd;

  vtlb_line_buffer vtlb_line_buffer_i (.clk(clk), .reset(reset), .tape_clk(tape_clk),
    .tape_sample(tape_sample), .tape_valid(tape_valid), .tape_dropout(tape_dropout),
    .tape_ready(tape_ready), .ref_take(ref_take), .out_sample(out_sample),
    .out_valid(out_valid), .out_substituted(out_substituted), .out_empty(out_empty),
    .out_fill(out_fill));
  vtlb_tape_model vtlb_tape_model_i (.tape_clk(tape_clk), .reset(reset),
    .tape_ready(tape_ready), .want(want), .tape_sample(tape_sample),
    .tape_valid(tape_valid), .tape_dropout(tape_dropout), .sent(sent), .stalls(stalls));

  // Reference clock and unrelated tape clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    tape_clk = 1'b0;
    #1.7;
    forever #3 tape_clk = ~tape_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // Read one sample and judge it; index rd counts reads since reset
  task automatic read_one();
    logic [7:0] e;
    logic s;
    int w;
    w = 0;
    while (out_empty !== 1'b0 && w < 100) begin
      @(posedge clk);
      #1;
      w++;
    end
    check({15'h0000, out_empty}, 16'h0000, "data never became readable");
    s = (rd % 97 == 50) && (rd >= 910);
    e = s ? 8'((rd - 910) * 37 + (rd - 910) / 256) : 8'(rd * 37 + rd / 256);
    ref_take = 1'b1;
    @(posedge clk);
    #1;
    ref_take = 1'b0;
    check({15'h0000, out_valid}, 16'h0001, "read strobe");
    check({7'h00, out_substituted, out_sample}, {7'h00, s, e}, "sample");
    rd++;
    // Let an edge pass so the next take is not raised in the step that lowered it
    @(posedge clk);
    #1;
  endtask : read_one

  // Wait under a bound for the source to reach its target or stall
  task automatic wait_source(input bit for_stall);
    int w;
    w = 0;
    while ((for_stall ? stalls == 0 : sent < want) && w < 20000) begin
      @(posedge clk);
      w++;
    end
    repeat (20) @(posedge clk);
    #1;
  endtask : wait_source

  // A take on an empty buffer yields nothing
  task automatic t_empty_take();
    ref_take = 1'b1;
    @(posedge clk);
    #1;
    ref_take = 1'b0;
    // A strobe would stand now, one cycle after the refused take
    check({15'h0000, out_valid}, 16'h0000, "take while empty");
    @(posedge clk);
    #1;
  endtask : t_empty_take

  // Fourteen lines absorbed without refusal, then read back in order
  task automatic t_window();
    want = 12740;
    wait_source(1'b0);
    check(16'(stalls), 16'h0000, "refused inside window");
    check({1'b0, out_fill}, {1'b0, vtlb_pkg::WINDOW_SPAN}, "fill at window");
    repeat (12740) read_one();
    check({1'b0, out_fill}, 16'h0000, "fill after drain");
    check({15'h0000, out_empty}, 16'h0001, "empty after drain");
    t_empty_take();
  endtask : t_window

  // Fill until refused, then drain across the wrap while writing resumes
  task automatic t_full();
    want = 12740 + 16000;
    wait_source(1'b1);
    check({1'b0, out_fill}, {1'b0, vtlb_pkg::FULL_AT}, "fill when full");
    check({15'h0000, tape_ready}, 16'h0000, "ready when full");
    repeat (16000) read_one();
    check({15'h0000, out_empty}, 16'h0001, "empty at end");
  endtask : t_full

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  // Main sequence
  initial begin
    reset = 1'b1;
    ref_take = 1'b0;
    want = 0;
    miscompares = 0;
    n_tests = 0;
    rd = 0;
    repeat (4) @(posedge clk);
    #1;
    check({10'h000, out_valid, out_empty, tape_ready, out_fill[2:0]}, 16'h0010, "reset");
    reset = 1'b0;
    t_empty_take();
    t_window();
    t_full();
    tally_and_finish();
  end

  // Watchdog against a hang
  initial begin
    #1_000_000;
    miscompares++;
    tally_and_finish();
  end
endmodule : tb_top

//--- vtlb_line_buffer.sv
// Dual-clock sample memory between off-tape timing and reference timing
`timescale 1ns/1ps
module vtlb_line_buffer (
  // Reference clock and reset
  input wire logic clk,
  input wire logic reset,
  // Off-tape side, burst-locked sample clock
  input wire logic tape_clk,
  input wire logic [vtlb_pkg::SAMPLE_W-1:0] tape_sample,
  input wire logic tape_valid,
  input wire logic tape_dropout,
  output logic tape_ready,
  // Reference side read
  input wire logic ref_take,
  output logic [vtlb_pkg::SAMPLE_W-1:0] out_sample,
  output logic out_valid,
  output logic out_substituted,
  output logic out_empty,
  output logic [vtlb_pkg::PTR_W-1:0] out_fill
);

  // Storage: sample plus dropout mark, written on tape clock only
  logic [vtlb_pkg::WORD_W-1:0] mem [vtlb_pkg::DEPTH];

  // Tape-domain state
  logic trst_meta_ff;
  logic trst_ff;
  logic [vtlb_pkg::PTR_W-1:0] wptr_ff;
  logic [vtlb_pkg::PTR_W-1:0] wgray_ff;
  logic [vtlb_pkg::PTR_W-1:0] rg_meta_ff;
  logic [vtlb_pkg::PTR_W-1:0] rg_sync_ff;
  logic [vtlb_pkg::PTR_W-1:0] rsync_bin;
  logic [vtlb_pkg::PTR_W-1:0] wr_used;
  logic wr_full;
  logic wr_go;

  // Reference-domain state
  logic [vtlb_pkg::PTR_W-1:0] rptr_ff;
  logic [vtlb_pkg::PTR_W-1:0] rgray_ff;
  logic [vtlb_pkg::PTR_W-1:0] wg_meta_ff;
  logic [vtlb_pkg::PTR_W-1:0] wg_sync_ff;
  logic [vtlb_pkg::PTR_W-1:0] wsync_bin;
  logic [vtlb_pkg::PTR_W-1:0] nxt_fill;
  logic lines_ok_ff;
  logic adj_ok;
  logic rd_empty;
  logic rd_go;
  logic use_adj;
  logic [vtlb_pkg::ADDR_W-1:0] cur_idx;
  logic [vtlb_pkg::ADDR_W-1:0] adj_idx;
  logic [vtlb_pkg::WORD_W-1:0] cur_word;
  logic [vtlb_pkg::WORD_W-1:0] adj_word;
  logic [vtlb_pkg::SAMPLE_W-1:0] out_sample_ff;
  logic out_valid_ff;
  logic out_sub_ff;
  logic [vtlb_pkg::PTR_W-1:0] fill_ff;

  // ---------------- Tape clock domain ----------------

  // Reset brought over to the tape clock; it must tick during reset
  always_ff @(posedge tape_clk) begin
    trst_meta_ff <= reset;
    trst_ff <= trst_meta_ff;
  end

  // Read pointer arrives as gray, one bit moves per step
  always_ff @(posedge tape_clk) begin
    if (trst_ff) begin
      rg_meta_ff <= vtlb_pkg::PTR_ZERO;
      rg_sync_ff <= vtlb_pkg::PTR_ZERO;
    end else begin
      rg_meta_ff <= rgray_ff;
      rg_sync_ff <= rg_meta_ff;
    end
  end

  // Occupancy seen by the writer; stale read pointer only errs safe
  assign rsync_bin = vtlb_pkg::gray2bin(rg_sync_ff);
  assign wr_used = wptr_ff - rsync_bin;
  // One line held back so the fill source is never overwritten
  assign wr_full = (wr_used >= vtlb_pkg::FULL_AT);
  // Room for well over the window, so fast play is not throttled early
  assign tape_ready = !trst_ff && !wr_full;
  assign wr_go = tape_valid && tape_ready;

  // Write pointer, one step per accepted sample
  always_ff @(posedge tape_clk) begin
    if (trst_ff) begin
      wptr_ff <= vtlb_pkg::PTR_ZERO;
    end else if (wr_go) begin
      wptr_ff <= wptr_ff + 15'h0001;
    end
  end

  // Gray copy for the reference side, registered so it cannot glitch
  always_ff @(posedge tape_clk) begin
    if (trst_ff) begin
      wgray_ff <= vtlb_pkg::PTR_ZERO;
    end else begin
      wgray_ff <= vtlb_pkg::bin2gray(wptr_ff);
    end
  end

  // Sample store at the next location, clocked by burst-locked clock
  always_ff @(posedge tape_clk) begin
    if (wr_go) begin
      mem[wptr_ff[vtlb_pkg::ADDR_W-1:0]] <= {tape_dropout, tape_sample};
    end
  end

  // ---------------- Reference clock domain ----------------

  // Write pointer brought over in gray
  always_ff @(posedge clk) begin
    if (reset) begin
      wg_meta_ff <= vtlb_pkg::PTR_ZERO;
      wg_sync_ff <= vtlb_pkg::PTR_ZERO;
    end else begin
      wg_meta_ff <= wgray_ff;
      wg_sync_ff <= wg_meta_ff;
    end
  end

  // Empty when reader has caught the synced writer
  assign wsync_bin = vtlb_pkg::gray2bin(wg_sync_ff);
  assign rd_empty = (rptr_ff == wsync_bin);
  assign rd_go = ref_take && !rd_empty;
  assign nxt_fill = wsync_bin - rptr_ff;

  // Current word and the same position one line back
  assign cur_idx = rptr_ff[vtlb_pkg::ADDR_W-1:0];
  assign adj_idx = cur_idx - vtlb_pkg::LINE_LEN[vtlb_pkg::ADDR_W-1:0];
  assign cur_word = mem[cur_idx];
  assign adj_word = mem[adj_idx];

  // No fill until a whole line has been read since reset
  assign adj_ok = lines_ok_ff || (rptr_ff >= vtlb_pkg::LINE_LEN);
  assign use_adj = cur_word[vtlb_pkg::DROP_BIT] && adj_ok;

  // Read pointer, same order as writes
  always_ff @(posedge clk) begin
    if (reset) begin
      rptr_ff <= vtlb_pkg::PTR_ZERO;
    end else if (rd_go) begin
      rptr_ff <= rptr_ff + 15'h0001;
    end
  end

  // Gray copy for the writer
  always_ff @(posedge clk) begin
    if (reset) begin
      rgray_ff <= vtlb_pkg::PTR_ZERO;
    end else begin
      rgray_ff <= vtlb_pkg::bin2gray(rptr_ff);
    end
  end

  // Sticky once the first line is behind the reader
  always_ff @(posedge clk) begin
    if (reset) begin
      lines_ok_ff <= 1'b0;
    end else if (rptr_ff >= vtlb_pkg::LINE_LEN) begin
      lines_ok_ff <= 1'b1;
    end
  end

  // Output strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      out_valid_ff <= 1'b0;
    end else begin
      out_valid_ff <= rd_go;
    end
  end

  // Output sample and fill mark, held between reads
  always_ff @(posedge clk) begin
    if (reset) begin
      out_sample_ff <= 8'h00;
      out_sub_ff <= 1'b0;
    end else if (rd_go) begin
      out_sample_ff <= use_adj ? adj_word[vtlb_pkg::SAMPLE_W-1:0] :
                                 cur_word[vtlb_pkg::SAMPLE_W-1:0];
      out_sub_ff <= use_adj;
    end
  end

  // Occupancy in samples, lags the tape side by the crossing
  always_ff @(posedge clk) begin
    if (reset) begin
      fill_ff <= vtlb_pkg::PTR_ZERO;
    end else begin
      fill_ff <= nxt_fill;
    end
  end

  assign out_sample = out_sample_ff;
  assign out_valid = out_valid_ff;
  assign out_substituted = out_sub_ff;
  assign out_empty = rd_empty;
  assign out_fill = fill_ff;

  // ---------------- Checks ----------------

  // Read request with data yields a sample next cycle
  a_take_gives_out: assert property (
    @(posedge clk) disable iff (reset)
    rd_go |=> out_valid
  ) else $error("accepted read produced no sample");

  // No sample without a request, nor from an empty store
  a_empty_no_out: assert property (
    @(posedge clk) disable iff (reset)
    (!ref_take || rd_empty) |=> !out_valid
  ) else $error("sample left while empty or unrequested");

  // Read pointer moves by one per taken sample
  a_read_order: assert property (
    @(posedge clk) disable iff (reset)
    rd_go |=> rptr_ff == $past(rptr_ff) + 15'h0001
  ) else $error("read pointer skipped or stalled");

  // Clean sample comes out untouched
  a_clean_passes: assert property (
    @(posedge clk) disable iff (reset)
    (rd_go && !cur_word[vtlb_pkg::DROP_BIT]) |=>
      (out_sample == $past(cur_word[vtlb_pkg::SAMPLE_W-1:0])) && !out_substituted
  ) else $error("clean sample altered");

  // Dropout fill taken from exactly one line back
  a_fill_aligned: assert property (
    @(posedge clk) disable iff (reset)
    (rd_go && cur_word[vtlb_pkg::DROP_BIT] && lines_ok_ff) |=>
      out_substituted && (out_sample == mem[$past(adj_idx)][vtlb_pkg::SAMPLE_W-1:0])
  ) else $error("dropout fill missing or shifted");

  // Reader never passes the writer nor lags beyond the store
  a_no_overtake: assert property (
    @(posedge clk) disable iff (reset)
    nxt_fill <= vtlb_pkg::DEPTH_P
  ) else $error("read pointer overtook write pointer");

  // Tape-side checks also idle on reset itself, as the tape reset copy starts unknown

  // Anything inside the window is accepted without refusal
  a_window_room: assert property (
    @(posedge tape_clk) disable iff (reset || trst_ff)
    (wr_used <= vtlb_pkg::WINDOW_SPAN) |-> tape_ready
  ) else $error("sample refused inside correction window");

  // Writer stops at the held-back limit
  a_write_limit: assert property (
    @(posedge tape_clk) disable iff (reset || trst_ff)
    wr_used <= vtlb_pkg::FULL_AT
  ) else $error("writer ran into protected line");

  // Accepted sample advances write address by one
  a_write_step: assert property (
    @(posedge tape_clk) disable iff (reset || trst_ff)
    wr_go |=> wptr_ff == $past(wptr_ff) + 15'h0001
  ) else $error("write address not consecutive");

  // Refused sample leaves pointer alone
  a_full_holds: assert property (
    @(posedge tape_clk) disable iff (reset || trst_ff)
    (tape_valid && !tape_ready) |=> $stable(wptr_ff)
  ) else $error("sample written while full");

  // Stored word matches the sample and mark it came with
  a_store_word: assert property (
    @(posedge tape_clk) disable iff (reset || trst_ff)
    wr_go |=> mem[$past(wptr_ff[vtlb_pkg::ADDR_W-1:0])] ==
              {$past(tape_dropout), $past(tape_sample)}
  ) else $error("stored word differs from input");

endmodule : vtlb_line_buffer

//--- vtlb_pkg.sv
// Constants and pointer helpers shared by the time-base line buffer
package vtlb_pkg;

  // Sample word and rate
  localparam int SAMPLE_W = 8;
  localparam int SAMPLES_PER_SUBCARRIER = 4;

  // Line geometry and correction window
  localparam int WINDOW_LINES = 14;
  localparam int ADDR_W = 14;
  localparam int PTR_W = ADDR_W + 1;
  localparam int WORD_W = SAMPLE_W + 1;
  localparam int DEPTH = 1 << ADDR_W;

  // Samples per line, pointer-width figures
  localparam logic [PTR_W-1:0] LINE_LEN = 15'h038e;
  localparam logic [PTR_W-1:0] DEPTH_P = 15'h4000;
  // One line of room is held back for dropout fill
  localparam logic [PTR_W-1:0] FULL_AT = DEPTH_P - LINE_LEN;
  localparam logic [PTR_W-1:0] WINDOW_SPAN = 15'h31c4;
  localparam logic [PTR_W-1:0] PTR_ZERO = 15'h0000;

  // Word layout in storage
  localparam int DROP_BIT = SAMPLE_W;

  // Binary to gray
  function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
    return b ^ (b >> 1);
  endfunction : bin2gray

  // Gray to binary
  function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b = g;
    for (int i = PTR_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction : gray2bin

endpackage : vtlb_pkg

//--- vtlb_tape_model.sv
// Behavioural playback source on the burst-locked tape clock
`timescale 1ns/1ps
module vtlb_tape_model (
  // Tape clock and reset
  input wire logic tape_clk,
  input wire logic reset,
  // Flow control from the buffer, sample target from the bench
  input wire logic tape_ready,
  input wire logic [31:0] want,
  // Sample stream
  output logic [vtlb_pkg::SAMPLE_W-1:0] tape_sample,
  output logic tape_valid,
  output logic tape_dropout,
  // Progress seen by the bench
  output int sent,
  output int stalls
);
  // Level code of the k-th sample
  function automatic logic [7:0] level(input int k);
    return 8'(k * 37 + k / 256);
  endfunction : level

  // One sample per tape clock; held unchanged until accepted
  initial begin
    sent = 0;
    stalls = 0;
    tape_valid = 1'b0;
    tape_sample = 8'h00;
    tape_dropout = 1'b0;
    forever begin
      @(posedge tape_clk);
      if (tape_valid && tape_ready) sent++;
      else if (tape_valid) stalls++;
      #1;
      if (!reset && sent < want) begin
        tape_valid = 1'b1;
        tape_sample = level(sent);
        tape_dropout = (sent % 97 == 50);
      end else begin
        // Idle lines toggle so a stale value never looks valid
        tape_valid = 1'b0;
        tape_sample = ~tape_sample;
        tape_dropout = ~tape_dropout;
      end
    end
  end
endmodule : vtlb_tape_model
